//--- src/cpu_interrupt_handler.sv
/*
  Interrupt request and vectoring logic with an AXI4-Lite register
  slave. Assumes the core sequencer pulses instrDone at each
  instruction boundary, retiDone when a return_from_interrupt
  completes, and vectorAck when it starts the long_call_to_vector.
  srcEvent comes from logic on clk_sys.
*/
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module cpu_interrupt_handler
  import cpu_irq_pkg::*;
#(
  parameter logic [cpu_irq_pkg::SRC_N*cpu_irq_pkg::VEC_W-1:0] VEC_TABLE =
    cpu_irq_pkg::defVecTable(),
  parameter logic [cpu_irq_pkg::SRC_N*cpu_irq_pkg::SRC_W-1:0] RANK_TABLE =
    cpu_irq_pkg::defRankTable(),
  parameter logic [cpu_irq_pkg::SRC_N-1:0] HW_CLR_MASK =
    cpu_irq_pkg::HW_CLR_DEF
) (
  input  wire logic                             clk_sys,
  input  wire logic                             rst_b,
  input  wire logic                             ce,
  input  wire logic [cpu_irq_pkg::SRC_N-1:0]    srcEvent,
  input  wire logic                             instrDone,
  input  wire logic                             retiDone,
  input  wire logic                             vectorAck,
  output var  logic                             vectorReq,
  output var  logic [cpu_irq_pkg::VEC_W-1:0]    vectorAddr,
  output var  logic [cpu_irq_pkg::SRC_W-1:0]    vectorSrc,
  output var  logic                             irq,
  input  wire logic [cpu_irq_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output var  logic                             s_axi_awready,
  input  wire logic [cpu_irq_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output var  logic                             s_axi_wready,
  output var  logic [1:0]                       s_axi_bresp,
  output var  logic                             s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [cpu_irq_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output var  logic                             s_axi_arready,
  output var  logic [cpu_irq_pkg::DATA_W-1:0]   s_axi_rdata,
  output var  logic [1:0]                       s_axi_rresp,
  output var  logic                             s_axi_rvalid,
  input  wire logic                             s_axi_rready
);
  import cpu_irq_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [VEC_W-1:0] vecOf(input logic [SRC_W-1:0] s);
    return VEC_TABLE[s*VEC_W +: VEC_W];
  endfunction

  // lowest rank among candidates wins
  function automatic logic [SRC_W-1:0] pickSrc(input logic [SRC_N-1:0] c);
    logic [SRC_W-1:0] best;
    logic [SRC_W-1:0] bestRank;
    logic             found;
    best     = '0;
    bestRank = '1;
    found    = 1'b0;
    for (int i = 0; i < SRC_N; i++) begin
      if (c[i] && (!found || RANK_TABLE[i*SRC_W +: SRC_W] < bestRank)) begin
        best     = SRC_W'(i);
        bestRank = RANK_TABLE[i*SRC_W +: SRC_W];
        found    = 1'b1;
      end
    end
    return best;
  endfunction

  function automatic logic [DATA_W-1:0] strbMask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic             globalEn_reg;
  logic [SRC_N-1:0] srcEn_reg;
  logic [SRC_N-1:0] prio_reg;
  logic [SRC_N-1:0] pend_reg,    pend_next;
  logic [SRC_N-1:0] cand_reg;
  logic             inSvcLow_reg, inSvcHigh_reg;
  logic             reqHigh_reg;
  logic [EVT_N-1:0] evtStat_reg, evtStat_next;
  logic [EVT_N-1:0] evtMask_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                    && !s_axi_awready;
  wire logic rdGo = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire logic [DATA_W-1:0] wMask  = strbMask(s_axi_wstrb);
  wire logic [DATA_W-1:0] wBits  = s_axi_wdata & wMask;
  wire logic wrCtrl    = wrGo && s_axi_awaddr == OFS_CTRL;
  wire logic wrSrcEn   = wrGo && s_axi_awaddr == OFS_SRC_EN;
  wire logic wrPrio    = wrGo && s_axi_awaddr == OFS_PRIO;
  wire logic wrPend    = wrGo && s_axi_awaddr == OFS_PEND;
  wire logic wrPendClr = wrGo && s_axi_awaddr == OFS_PEND_CLR;
  wire logic wrEvtStat = wrGo && s_axi_awaddr == OFS_EVT_STAT;
  wire logic wrEvtMask = wrGo && s_axi_awaddr == OFS_EVT_MASK;
  wire logic wrHit = wrCtrl || wrSrcEn || wrPrio || wrPend || wrPendClr
                     || wrEvtStat || wrEvtMask
                     || (wrGo && s_axi_awaddr == OFS_STATE);

  wire logic [DATA_W-1:0] stateWord =
    DATA_W'({vectorSrc, 1'b0, vectorReq, inSvcHigh_reg, inSvcLow_reg});
  logic [DATA_W-1:0] rdWord;
  logic              rdHit;
  always_comb begin
    rdHit  = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL:     rdWord = DATA_W'(globalEn_reg);
      OFS_SRC_EN:   rdWord = DATA_W'(srcEn_reg);
      OFS_PRIO:     rdWord = DATA_W'(prio_reg);
      OFS_PEND:     rdWord = DATA_W'(pend_reg);
      OFS_PEND_CLR: rdWord = '0;
      OFS_STATE:    rdWord = stateWord;
      OFS_EVT_STAT: rdWord = DATA_W'(evtStat_reg);
      OFS_EVT_MASK: rdWord = DATA_W'(evtMask_reg);
      default: begin
        rdWord = '0;
        rdHit  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  wire logic [SRC_N-1:0] candNow = pend_reg & srcEn_reg
                                   & {SRC_N{globalEn_reg}};
  wire logic [SRC_N-1:0] hiCand = cand_reg & prio_reg
                                  & {SRC_N{!inSvcHigh_reg}};
  wire logic [SRC_N-1:0] loCand = cand_reg & ~prio_reg
                                  & {SRC_N{!inSvcHigh_reg && !inSvcLow_reg}};
  wire logic hasHi = |hiCand;
  wire logic hasAny = hasHi || |loCand;
  wire logic [SRC_W-1:0] selSrc = hasHi ? pickSrc(hiCand)
                                        : pickSrc(loCand);
  wire logic launch = !vectorReq && instrDone && !retiDone
                      && hasAny;
  wire logic taken  = vectorReq && vectorAck;
  wire logic [SRC_N-1:0] hwClr = taken
    ? (HW_CLR_MASK & (SRC_N'(1) << vectorSrc)) : '0;

  // software clears lose against a same-cycle hardware set
  assign pend_next = (pend_reg & ~hwClr
                      & ~(wrPendClr ? wBits[SRC_N-1:0] : '0))
                     | srcEvent
                     | (wrPend ? wBits[SRC_N-1:0] : '0);

  wire logic [EVT_N-1:0] evtSet =
    {taken && reqHigh_reg && inSvcLow_reg, retiDone, taken};
  assign evtStat_next = (evtStat_reg
                         & ~(wrEvtStat ? wBits[EVT_N-1:0] : '0)) | evtSet;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      globalEn_reg <= GEN_RST;
      srcEn_reg    <= SRC_RST;
      prio_reg     <= SRC_RST;
      evtMask_reg  <= EVT_RST;
    end else if (ce) begin
      if (wrCtrl) globalEn_reg <= wBits[CTRL_GEN_BIT] |
        (globalEn_reg & !wMask[CTRL_GEN_BIT]);
      if (wrSrcEn) srcEn_reg <= (srcEn_reg & ~wMask[SRC_N-1:0])
                                | wBits[SRC_N-1:0];
      if (wrPrio) prio_reg <= (prio_reg & ~wMask[SRC_N-1:0])
                              | wBits[SRC_N-1:0];
      if (wrEvtMask) evtMask_reg <= (evtMask_reg & ~wMask[EVT_N-1:0])
                                    | wBits[EVT_N-1:0];
    end
  end

  // ----------------------------------------------------------------
  // pending flags, detection, events
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pend_reg    <= SRC_RST;
      cand_reg    <= SRC_RST;
      evtStat_reg <= EVT_RST;
      irq         <= 1'b0;
    end else if (ce) begin
      pend_reg    <= pend_next;
      cand_reg    <= candNow;
      evtStat_reg <= evtStat_next;
      irq         <= |(evtStat_reg & evtMask_reg);
    end
  end

  // ----------------------------------------------------------------
  // vectoring and service levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vectorReq     <= 1'b0;
      vectorAddr    <= '0;
      vectorSrc     <= '0;
      reqHigh_reg   <= 1'b0;
      inSvcLow_reg  <= 1'b0;
      inSvcHigh_reg <= 1'b0;
    end else if (ce) begin
      if (launch) begin
        vectorReq   <= 1'b1;
        vectorSrc   <= selSrc;
        vectorAddr  <= vecOf(selSrc);
        reqHigh_reg <= hasHi;
      end else if (taken) begin
        vectorReq <= 1'b0;
      end
      if (taken && reqHigh_reg) inSvcHigh_reg <= 1'b1;
      else if (retiDone && inSvcHigh_reg) inSvcHigh_reg <= 1'b0;
      if (taken && !reqHigh_reg) inSvcLow_reg <= 1'b1;
      else if (retiDone && !inSvcHigh_reg) inSvcLow_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
    end else if (ce) begin
      s_axi_awready <= wrGo;
      s_axi_wready  <= wrGo;
      s_axi_arready <= rdGo;
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_GLOBAL_GATE: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    $rose(vectorReq) |-> $past(globalEn_reg, 2))
    else $error("vector request raised with global enable off");

  AST_AT_BOUNDARY: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    $rose(vectorReq) |-> $past(instrDone) && !$past(retiDone))
    else $error("vector request not at an instruction boundary");

  AST_VECTOR_ADDR: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    vectorReq |-> vectorAddr == vecOf(vectorSrc))
    else $error("vector address does not match source");

  AST_SOURCE_ENABLED: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    $rose(vectorReq) |-> |($past(srcEn_reg, 2) & $past(pend_reg, 2)
                           & (SRC_N'(1) << vectorSrc)))
    else $error("request for a disabled or idle source");

  AST_FLAG_SET: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    |srcEvent |=> (pend_reg & $past(srcEvent)) == $past(srcEvent))
    else $error("pending flag missed its event");

  AST_HW_CLEAR: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    taken && HW_CLR_MASK[vectorSrc] && !srcEvent[vectorSrc] && !wrPend
    |=> !pend_reg[$past(vectorSrc)])
    else $error("hardware-cleared flag still set after vectoring");

  AST_RETURN_REENTRY: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    instrDone && !retiDone && !vectorReq && hasAny |=> vectorReq)
    else $error("no re-entry after one further instruction");

  AST_LOW_WAITS: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    $rose(vectorReq) && !reqHigh_reg |-> !$past(inSvcLow_reg)
                                         && !$past(inSvcHigh_reg))
    else $error("low-priority request entered a running routine");

  AST_HIGH_ALONE: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    $rose(vectorReq) |-> !$past(inSvcHigh_reg))
    else $error("high-priority routine was preempted");

  AST_HIGH_FIRST: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    $rose(vectorReq) |-> reqHigh_reg == $past(hasHi))
    else $error("lower level chosen over a high request");

  AST_IRQ_LEVEL: assert property (@(posedge clk_sys)
    disable iff (!rst_b || !ce)
    taken && evtMask_reg[EVT_TAKEN] |-> ##2 irq)
    else $error("interrupt output missed a masked-in event");

endmodule // cpu_interrupt_handler

`default_nettype wire

//--- src/cpu_irq_pkg.sv
/*
  Constants for the interrupt request and vectoring block: register
  offsets, reset values, field positions, source table defaults.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
`default_nettype none

package cpu_irq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SRC_N  = 15;
  localparam int SRC_W  = 4;
  localparam int VEC_W  = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SRC_EN   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRIO     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PEND     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PEND_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATE    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h1C;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_GEN_BIT   = 0;
  localparam int STATE_LOW_BIT  = 0;
  localparam int STATE_HIGH_BIT = 1;
  localparam int STATE_REQ_BIT  = 2;
  localparam int STATE_SRC_LSB  = 4;
  localparam int EVT_N          = 3;
  localparam int EVT_TAKEN      = 0;
  localparam int EVT_RETURN     = 1;
  localparam int EVT_PREEMPT    = 2;

  localparam logic             GEN_RST  = 1'b0;
  localparam logic [SRC_N-1:0] SRC_RST  = 15'h0000;
  localparam logic [EVT_N-1:0] EVT_RST  = 3'h0;
  localparam logic [SRC_N-1:0] HW_CLR_DEF = 15'h000F;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // default vector and arbitration tables
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_BASE   = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STRIDE = 16'h0008;

  function automatic logic [SRC_N*VEC_W-1:0] defVecTable();
    logic [SRC_N*VEC_W-1:0] t;
    t = '0;
    for (int i = 0; i < SRC_N; i++) begin
      t[i*VEC_W +: VEC_W] = VEC_BASE + VEC_STRIDE * VEC_W'(i);
    end
    return t;
  endfunction

  function automatic logic [SRC_N*SRC_W-1:0] defRankTable();
    logic [SRC_N*SRC_W-1:0] t;
    t = '0;
    for (int i = 0; i < SRC_N; i++) begin
      t[i*SRC_W +: SRC_W] = SRC_W'(i);
    end
    return t;
  endfunction

endpackage

`default_nettype wire

//--- verif/core_seq_model.sv
/*
  Core sequencer model: instruction boundaries every period cycles,
  vector acknowledge ackWait+1 cycles after vectorReq rises, return on request.
  Assumes the bench holds retiCmd high until it sees retiDone.
*/
`timescale 1ns/10ps
`default_nettype none

module core_seq_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [3:0] period,
  input  wire logic [2:0] ackWait,
  input  wire logic       retiCmd,
  input  wire logic       vectorReq,
  output var  logic       instrDone,
  output var  logic       retiDone,
  output var  logic       vectorAck
);
  logic [3:0] instrCnt;
  logic [2:0] ackCnt;
  logic       boundary;
  logic       ackNow;
  logic       retiNow;

  // no instruction retires while a vector call is pending
  assign boundary = !vectorReq && instrCnt >= period - 4'h1;
  assign ackNow   = vectorReq && !vectorAck && ackCnt == ackWait;
  assign retiNow  = boundary && retiCmd && !retiDone;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      instrCnt  <= 4'h0;
      ackCnt    <= 3'h0;
      instrDone <= 1'h0;
      retiDone  <= 1'h0;
      vectorAck <= 1'h0;
    end else begin
      instrCnt  <= boundary ? 4'h0 : instrCnt + 4'h1;
      ackCnt    <= (vectorReq && !vectorAck && !ackNow) ? ackCnt + 3'h1
                                                         : 3'h0;
      vectorAck <= ackNow;
      instrDone <= boundary && !retiNow;
      retiDone  <= retiNow;
    end
  end
endmodule // core_seq_model

`default_nettype wire

//--- verif/tb_top.sv
/*
  Self-checking bench for cpu_interrupt_handler.
  Assumes core_seq_model on the core link and package defaults.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import cpu_irq_pkg::*;

  logic              clk_sys = 1'h0;
  logic              rst_b = 1'h0;
  logic              ce = 1'h1;
  logic [SRC_N-1:0]  srcEvent = '0;
  logic [3:0]        period = 4'h4;
  logic [2:0]        ackWait = 3'h2;
  logic              retiCmd = 1'h0;
  logic              instrDone, retiDone, vectorAck, vectorReq, irq;
  logic [VEC_W-1:0]  vectorAddr;
  logic [SRC_W-1:0]  vectorSrc;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic              s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic              s_axi_rready = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                n;
  int                k;
  logic [14:0]       tMask [3] = '{15'h0108, 15'h0050, 15'h0004};
  logic [3:0]        tSrc [3] = '{4'h8, 4'h4, 4'h2};
  logic [14:0]       tPend [3] = '{15'h0108, 15'h0050, 15'h0000};

  always #2 clk_sys = ~clk_sys;

  cpu_interrupt_handler u_dut (
    .clk_sys, .rst_b, .ce, .srcEvent, .instrDone, .retiDone, .vectorAck,
    .vectorReq, .vectorAddr, .vectorSrc, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  core_seq_model u_core (
    .clk_sys, .rst_b, .period, .ackWait, .retiCmd, .vectorReq,
    .instrDone, .retiDone, .vectorAck
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'h1; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    check(32'(s_axi_bvalid), 32'h1);
    check(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'h1; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    check(s_axi_rdata, e);
    check(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic pulse(input logic [14:0] m);
    @(posedge clk_sys);
    srcEvent <= m;
    @(posedge clk_sys);
    srcEvent <= '0;
  endtask

  task automatic waitReq(input logic v);
    int i;
    for (i = 0; i < 60 && vectorReq !== v; i++) @(posedge clk_sys);
    check(32'(vectorReq), 32'(v));
  endtask

  task automatic quiet(input int c);
    logic seen;
    seen = 1'h0;
    repeat (c) begin
      @(posedge clk_sys);
      if (vectorReq !== 1'h0) seen = 1'h1;
    end
    check(32'(seen), 32'h0);
  endtask

  task automatic return_from_interrupt();
    int i;
    @(posedge clk_sys);
    retiCmd <= 1'h1;
    for (i = 0; i < 60 && retiDone !== 1'h1; i++) @(posedge clk_sys);
    retiCmd <= 1'h0;
    check(32'(retiDone), 32'h1);
  endtask

  task automatic serve(input logic [14:0] m, input logic [3:0] s,
                       input logic [14:0] p);
    if (m != '0) pulse(m);
    waitReq(1'h1);
    check(32'(vectorSrc), 32'(s));
    check(32'(vectorAddr), 32'(VEC_BASE + VEC_STRIDE * VEC_W'(s)));
    waitReq(1'h0);
    rdChk(OFS_PEND, 32'(p));
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    for (int i = 0; i < 8; i++) rdChk(8'(4 * i), 32'h0);
    rdChk(8'h20, 32'h0, RESP_SLVERR);
    axiWr(8'h40, 32'h1, RESP_SLVERR);
    axiWr(OFS_SRC_EN, 32'h20);
    pulse(15'h0020);
    quiet(12);
    rdChk(OFS_PEND, 32'h20);
    axiWr(OFS_SRC_EN, 32'h0);
    axiWr(OFS_CTRL, 32'h1);
    quiet(12);
    axiWr(OFS_EVT_MASK, 32'h1);
    axiWr(OFS_SRC_EN, 32'h20);
    serve('0, 4'h5, 15'h0020);
    rdChk(OFS_STATE, 32'h51);
    check(32'(irq), 32'h1);
    return_from_interrupt();
    k = 0;
    for (n = 0; n < 60 && vectorReq !== 1'h1; n++) begin
      @(posedge clk_sys);
      if (instrDone === 1'h1) k++;
    end
    check(32'(k), 32'h1);
    waitReq(1'h0);
    axiWr(OFS_PEND_CLR, 32'h20);
    return_from_interrupt();
    quiet(12);
    rdChk(OFS_STATE, 32'h50);
    axiWr(OFS_PRIO, 32'h180);
    axiWr(OFS_SRC_EN, 32'h7FFF);
    serve(15'h0020, 4'h5, 15'h0020);
    serve(15'h0080, 4'h7, 15'h00A0);
    rdChk(OFS_STATE, 32'h73);
    pulse(15'h0140);
    quiet(12);
    axiWr(OFS_PEND_CLR, 32'h80);
    return_from_interrupt();
    serve('0, 4'h8, 15'h0160);
    axiWr(OFS_PEND_CLR, 32'h100);
    return_from_interrupt();
    rdChk(OFS_STATE, 32'h81);
    axiWr(OFS_PEND_CLR, 32'h7FFF);
    return_from_interrupt();
    for (int i = 0; i < 3; i++) begin
      serve(tMask[i], tSrc[i], tPend[i]);
      axiWr(OFS_PEND_CLR, 32'h7FFF);
      return_from_interrupt();
    end
    period <= 4'h1;
    ackWait <= 3'h0;
    @(posedge clk_sys);
    srcEvent <= 15'h0400;
    n = 0;
    while (vectorReq !== 1'h1 && n < 20) begin
      @(posedge clk_sys);
      srcEvent <= '0;
      n++;
    end
    check(32'(n), 32'h4);
    waitReq(1'h0);
    axiWr(OFS_PEND_CLR, 32'h400);
    return_from_interrupt();
    axiWr(OFS_PEND, 32'h800);
    serve('0, 4'hB, 15'h0800);
    axiWr(OFS_PEND_CLR, 32'h800);
    return_from_interrupt();
    rdChk(OFS_EVT_STAT, 32'h7);
    check(32'(irq), 32'h1);
    axiWr(OFS_EVT_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h0);
    axiWr(OFS_EVT_STAT, 32'h7);
    rdChk(OFS_EVT_STAT, 32'h0);
    ce <= 1'h0;
    pulse(15'h1000);
    ce <= 1'h1;
    rdChk(OFS_PEND, 32'h0);
    give_verdict();
  end

  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
